// ==== core/spi_host_port.sv ====
// spi slave host port with transmit fifo and data notify line
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - slave only; sck and chip select are inputs, never driven.
// - port stays disabled after reset until enabled and configured by user.
// - notify output asserted while the port is enabled and transmit data is waiting for the host.
// - link works to 6 Mbps; host must not clock faster.

// generic fifo, width and depth parameterised
module spi_byte_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  // clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             reset_n_i,
  // fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  // honest full and empty from the occupancy count
  assign in_ready_o  = (cnt_q < (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rd_q];
  assign push = in_valid_i && in_ready_o;
  assign pop  = out_valid_o && out_ready_i;

  // pointer and count update
  always_comb begin
    wr_d  = push ? wr_q + 1'b1 : wr_q;
    rd_d  = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // storage has no reset; only written entries are read
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end
endmodule : spi_byte_fifo

module spi_host_port
  import spi_host_port_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              reset_n_i,
  // configuration from the user
  input  wire logic              port_enable_i,
  input  wire spi_mode_t         mode_i,
  // module data toward the host
  input  wire logic              tx_valid_i,
  output logic                   tx_ready_o,
  input  wire logic [DATA_W-1:0] tx_data_i,
  // host data received
  output logic                   rx_valid_o,
  output logic      [DATA_W-1:0] rx_data_o,
  // spi pins, host is master
  input  wire logic              spi_sck_i,
  input  wire logic              spi_cs_n_i,
  input  wire logic              spi_mosi_i,
  output logic                   spi_miso_o,
  output logic                   spi_miso_oe_n_o,
  // notify line toward the host
  output logic                   host_data_notify_o
);
  // three-stage synchronisers; stage 1 feeds only stage 2
  spi_pins_t s1_q, s2_q, s3_q, pin_q, pin_d;
  logic      en_q, en_d;
  spi_mode_t mode_q, mode_d;
  logic [2:0]        bit_q, bit_d;
  logic [DATA_W-1:0] sh_q, sh_d, tx_q, tx_d, rxd_q, rxd_d;
  logic              miso_q, miso_d, rxv_q, rxv_d, loaded_q, loaded_d;
  logic              f_valid, f_pop;
  logic [DATA_W-1:0] f_data;
  logic              lead, trail, samp_edge, shift_edge, cs_fall, byte_start;

  spi_byte_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (tx_valid_i && en_q),
    .in_ready_o  (tx_ready_o),
    .in_data_i   (tx_data_i),
    .out_valid_o (f_valid),
    .out_ready_i (f_pop),
    .out_data_o  (f_data)
  );

  // a level counts once stages two and three agree, else hold
  function automatic logic settle(input logic a, input logic b, input logic old);
    settle = (a == b) ? a : old;
  endfunction : settle

  always_comb begin
    pin_d.sck  = settle(s2_q.sck, s3_q.sck, pin_q.sck);
    pin_d.cs_n = settle(s2_q.cs_n, s3_q.cs_n, pin_q.cs_n);
    pin_d.mosi = settle(s2_q.mosi, s3_q.mosi, pin_q.mosi);
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1_q  <= '{sck: 1'b0, cs_n: 1'b1, mosi: 1'b0};
      s2_q  <= '{sck: 1'b0, cs_n: 1'b1, mosi: 1'b0};
      s3_q  <= '{sck: 1'b0, cs_n: 1'b1, mosi: 1'b0};
      pin_q <= '{sck: 1'b0, cs_n: 1'b1, mosi: 1'b0};
    end else begin
      s1_q  <= '{sck: spi_sck_i, cs_n: spi_cs_n_i, mosi: spi_mosi_i};
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      pin_q <= pin_d;
    end
  end

  // edges in the master's mode; cpha picks which edge samples
  // four clocks of sync latency leave one clock of margin at the rate limit
  assign lead       = pin_q.sck == mode_q.cpol && pin_d.sck != mode_q.cpol;
  assign trail      = pin_q.sck != mode_q.cpol && pin_d.sck == mode_q.cpol;
  assign samp_edge  = mode_q.cpha ? trail : lead;
  assign shift_edge = mode_q.cpha ? lead : trail;
  assign cs_fall    = pin_q.cs_n && !pin_d.cs_n;
  // a byte opens at select or at the shift edge that follows a full byte
  assign byte_start = en_q && !pin_d.cs_n &&
                      (cs_fall || (shift_edge && bit_q == BIT_CNT_RESET));
  // the head leaves the fifo only once the host has sampled its msb,
  // so a frame that ends on a freshly shown msb loses nothing
  assign f_pop      = en_q && !pin_d.cs_n && samp_edge && bit_q == BIT_CNT_RESET &&
                      loaded_q && f_valid;

  // byte engine; mode is latched only while idle so a frame never changes mid-byte
  always_comb begin
    en_d     = port_enable_i;
    mode_d   = (pin_q.cs_n || !en_q) ? mode_i : mode_q;
    bit_d    = bit_q;
    sh_d     = sh_q;
    tx_d     = tx_q;
    miso_d   = miso_q;
    rxd_d    = rxd_q;
    rxv_d    = 1'b0;
    loaded_d = loaded_q;
    if (!en_q || pin_d.cs_n) begin
      bit_d    = BIT_CNT_RESET;
      loaded_d = 1'b0;
    end else begin
      if (byte_start) begin
        // show the head msb; an empty fifo shifts out zeros
        miso_d   = f_valid ? f_data[DATA_W-1] : 1'b0;
        loaded_d = f_valid;
      end else if (shift_edge) begin
        miso_d = tx_q[bit_q];
      end
      if (samp_edge) begin
        sh_d  = {sh_q[DATA_W-2:0], pin_d.mosi};
        bit_d = bit_q - 3'h1;
        if (bit_q == BIT_CNT_RESET) begin
          tx_d     = f_pop ? f_data : '0;
          loaded_d = 1'b0;
        end
        if (bit_q == 3'h0) begin
          bit_d = BIT_CNT_RESET;
          rxd_d = {sh_q[DATA_W-2:0], pin_d.mosi};
          rxv_d = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      en_q     <= ENABLE_RESET;
      mode_q   <= '0;
      bit_q    <= BIT_CNT_RESET;
      sh_q     <= '0;
      tx_q     <= '0;
      miso_q   <= 1'b0;
      rxd_q    <= '0;
      rxv_q    <= 1'b0;
      loaded_q <= 1'b0;
    end else begin
      en_q     <= en_d;
      mode_q   <= mode_d;
      bit_q    <= bit_d;
      sh_q     <= sh_d;
      tx_q     <= tx_d;
      miso_q   <= miso_d;
      rxd_q    <= rxd_d;
      rxv_q    <= rxv_d;
      loaded_q <= loaded_d;
    end
  end

  // outputs; miso driven only in a selected enabled frame
  assign spi_miso_o         = miso_q;
  assign spi_miso_oe_n_o    = !(en_q && !pin_q.cs_n);
  assign rx_valid_o         = rxv_q;
  assign rx_data_o          = rxd_q;
  assign host_data_notify_o = en_q && f_valid;

  property p_disabled_quiet;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      !en_q |-> spi_miso_oe_n_o && !host_data_notify_o && !rx_valid_o;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("port active while disabled");

  property p_notify_pending;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      en_q && f_valid |-> host_data_notify_o;
  endproperty
  a_notify_pending: assert property (p_notify_pending)
    else $error("notify low with data waiting");

  property p_no_drive_unselected;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      pin_q.cs_n |-> spi_miso_oe_n_o;
  endproperty
  a_no_drive_unselected: assert property (p_no_drive_unselected)
    else $error("miso driven without chip select");

  property p_enable_follows;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      $rose(port_enable_i) |=> en_q;
  endproperty
  a_enable_follows: assert property (p_enable_follows)
    else $error("enable not taken");

  property p_rx_after_byte;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      rx_valid_o |-> $past(bit_q) == 3'h0 && $past(samp_edge);
  endproperty
  a_rx_after_byte: assert property (p_rx_after_byte)
    else $error("byte out of step");

  property p_rx_msb_first;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      rx_valid_o |-> rx_data_o[DATA_W-1:1] == $past(sh_q[DATA_W-2:0]);
  endproperty
  a_rx_msb_first: assert property (p_rx_msb_first)
    else $error("receive order wrong");

  // a byte that opens with data waiting shows the head msb next cycle
  sequence s_byte_open;
    byte_start && f_valid;
  endsequence
  property p_head_msb_out;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      s_byte_open |=> spi_miso_o == $past(f_data[DATA_W-1]);
  endproperty
  a_head_msb_out: assert property (p_head_msb_out)
    else $error("byte start does not show the head msb");
endmodule : spi_host_port
`default_nettype wire

// ==== core/spi_host_port_pkg.sv ====
// shared constants and types for the spi slave host port
package spi_host_port_pkg;
  localparam int unsigned DATA_W          = 8;
  localparam int unsigned FIFO_DEPTH      = 32;
  localparam int unsigned CLK_HZ          = 50000000;
  localparam int unsigned MAX_BIT_RATE_BPS = 6000000;
  // least sck half period in ref clocks, rounded up
  localparam int unsigned MIN_HALF_CYCLES =
    (CLK_HZ + 2 * MAX_BIT_RATE_BPS - 1) / (2 * MAX_BIT_RATE_BPS);
  localparam logic [2:0] BIT_CNT_RESET = 3'h7;
  localparam logic       ENABLE_RESET  = 1'b0;

  // spi mode selection carried as one unit
  typedef struct packed {
    logic cpol;
    logic cpha;
  } spi_mode_t;

  // synchronised pin levels
  typedef struct packed {
    logic sck;
    logic cs_n;
    logic mosi;
  } spi_pins_t;
endpackage : spi_host_port_pkg

// ==== verif/spi_host_master_model.sv ====
// behavioural spi master standing in for the external host
`timescale 1ns/1ns
`default_nettype none
module spi_host_master_model #(
  parameter int HALF = 5
) (
  input  wire logic ref_clk_i,
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      mosi_o,
  input  wire logic miso_i
);
  initial begin
    sck_o  = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // one sck half period, changes land just after a clock edge
  task automatic hp();
    repeat (HALF) @(posedge ref_clk_i);
    #1;
  endtask : hp
  // the model alone makes sck and chip select half period at the rate limit
  task automatic xfer(input logic cpol, input logic cpha, input logic [7:0] tx,
                      output logic [7:0] rx);
    sck_o = cpol;
    hp();
    cs_n_o = 1'b0;
    hp();
    // msb first in every mode
    for (int i = 7; i >= 0; i--) begin
      if (!cpha) mosi_o = tx[i];
      hp();
      sck_o = ~cpol;
      if (!cpha) rx[i] = miso_i;
      else mosi_o = tx[i];
      hp();
      sck_o = cpol;
      if (cpha) rx[i] = miso_i;
    end
    hp();
    cs_n_o = 1'b1;
    // released line shows the inverse, never the stale bit
    mosi_o = ~mosi_o;
    hp();
  endtask : xfer
endmodule : spi_host_master_model
`default_nettype wire

// ==== verif/spi_host_port_tb.sv ====
// self-checking bench for the spi slave host port
`timescale 1ns/1ns
`default_nettype none
module spi_host_port_tb;
  import spi_host_port_pkg::*;
  logic        ref_clk_i = 1'b0, reset_n_i = 1'b0, port_enable_i = 1'b0, tx_valid_i = 1'b0;
  spi_mode_t   mode_i = '0;
  logic [7:0]  tx_data_i = 8'h00, rx_data_o, got, exp_b;
  logic        tx_ready_o, rx_valid_o, sck, cs_n, mosi, miso, miso_oe_n, notify;
  logic [7:0]  rxq[$], txq[$];
  int          errors = 0, checks_done = 0;
  initial forever #10 ref_clk_i = ~ref_clk_i;
  spi_host_port i_dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .port_enable_i(port_enable_i), .mode_i(mode_i), .tx_valid_i(tx_valid_i),
    .tx_ready_o(tx_ready_o), .tx_data_i(tx_data_i), .rx_valid_o(rx_valid_o),
    .rx_data_o(rx_data_o), .spi_sck_i(sck), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi),
    .spi_miso_o(miso), .spi_miso_oe_n_o(miso_oe_n), .host_data_notify_o(notify));
  spi_host_master_model #(.HALF(MIN_HALF_CYCLES)) i_host (.ref_clk_i(ref_clk_i),
    .sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));
  // collect every received byte in the cycle its pulse stands
  always @(posedge ref_clk_i) if (rx_valid_o === 1'b1) rxq.push_back(rx_data_o);
  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out
  // hold valid and data until the edge where ready is high
  task automatic push(logic [7:0] d);
    int n;
    n = 0;
    tx_data_i  = d;
    tx_valid_i = 1'b1;
    while (tx_ready_o !== 1'b1 && n < 50) begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    if (n >= 50) begin
      errors++;
      close_out();
    end
    @(posedge ref_clk_i);
    #1;
  endtask : push
  initial begin
    repeat (100000) @(posedge ref_clk_i);
    errors++;
    close_out();
  end
  initial begin
    void'($urandom(23820));
    repeat (3) @(posedge ref_clk_i);
    #1 reset_n_i = 1'b1;
    @(posedge ref_clk_i);
    #1;
    chk("notify", 8'h0, {7'h0, notify});
    chk("miso_oe_n", 8'h1, {7'h0, miso_oe_n});
    $display("test reset done");
    // disabled port drops pushes and ignores the host
    push(8'h5a);
    tx_valid_i = 1'b0;
    i_host.xfer(1'b0, 1'b0, 8'hc3, got);
    chk("notify", 8'h0, {7'h0, notify});
    chk("rx_count", 8'h0, 8'(rxq.size()));
    $display("test disabled done");
    // enable, fill the fifo until it refuses
    port_enable_i = 1'b1;
    repeat (2) @(posedge ref_clk_i);
    #1;
    for (int k = 0; k < 32; k++) begin
      exp_b = (k == 0) ? 8'h80 : (k == 1) ? 8'h01 : 8'($urandom);
      txq.push_back(exp_b);
      push(exp_b);
    end
    tx_valid_i = 1'b0;
    @(posedge ref_clk_i);
    #1;
    chk("tx_ready", 8'h0, {7'h0, tx_ready_o});
    chk("notify", 8'h1, {7'h0, notify});
    $display("test fill done");
    // drain through all four modes, notify checked high before each host transfer
    for (int k = 0; k < 32; k++) begin
      mode_i = spi_mode_t'(k[1:0]);
      exp_b  = 8'($urandom);
      chk("notify", 8'h1, {7'h0, notify});
      i_host.xfer(mode_i.cpol, mode_i.cpha, exp_b, got);
      chk("miso_byte", txq.pop_front(), got);
      for (int n = 0; n < 20 && rxq.size() == 0; n++) begin
        @(posedge ref_clk_i);
        #1;
      end
      chk("rx_data", exp_b, (rxq.size() > 0) ? rxq.pop_front() : 8'hxx);
    end
    chk("notify", 8'h0, {7'h0, notify});
    chk("miso_oe_n", 8'h1, {7'h0, miso_oe_n});
    $display("test drain done");
    close_out();
  end
endmodule : spi_host_port_tb
`default_nettype wire
